// file: design/hpdr_fifo.sv
// small queue with registered read data
// assumes push only when not full and pop only when not empty
module hpdr_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic srst,
	hpdr_fifo_if.queue q
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic [W-1:0] rdata_q;
	logic do_push;
	logic do_pop;

	assign do_push = q.push && !q.full;
	assign do_pop = q.pop && !q.empty;
	assign q.full = (cnt_q == (AW+1)'(DEPTH));
	assign q.empty = (cnt_q == '0);
	assign q.rdata = rdata_q;

	always_ff @(posedge mclk)
	begin
		if (do_push)
			mem[wp_q] <= q.wdata;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			rdata_q <= '0;
		end
		else
		begin
			if (do_push)
				wp_q <= wp_q + 1'b1;
			if (do_pop)
			begin
				rp_q <= rp_q + 1'b1;
				rdata_q <= mem[rp_q];
			end
			if (do_push && !do_pop)
				cnt_q <= cnt_q + 1'b1;
			else if (do_pop && !do_push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule : hpdr_fifo

// file: design/hpdr_fifo_if.sv
// signals between the top and one queue instance
// assumes one clock shared by both ends
interface hpdr_fifo_if #(parameter int W = 32);
	logic push;
	logic [W-1:0] wdata;
	logic full;
	logic pop;
	logic [W-1:0] rdata;
	logic empty;
	modport owner (output push, output wdata, output pop,
		input full, input rdata, input empty);
	modport queue (input push, input wdata, input pop,
		output full, output rdata, output empty);
endinterface : hpdr_fifo_if

// file: design/hpdr_fix.sv
// no logic

// file: design/hpdr_pkg.sv
// constants for the host port data and address register block
// assumes a 32-bit ahb-lite slave path and a word-wide memory port
package hpdr_pkg;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int FIFO_DEPTH = 8;
	// ahb byte offsets of the cpu-visible registers
	localparam logic [7:0] OFS_RD_PTR = 8'h00;
	localparam logic [7:0] OFS_WR_PTR = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	// status field positions
	localparam int ST_DUAL_POS = 0;
	localparam int ST_WF_EMPTY_POS = 1;
	localparam int ST_RF_EMPTY_POS = 2;
	localparam int ST_BUSY_POS = 3;
	// reset values
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [31:0] PTR_RST = 32'h0000_0000;
	// host select codes
	localparam logic [1:0] SEL_DATA = 2'h0;
	localparam logic [1:0] SEL_RPTR = 2'h1;
	localparam logic [1:0] SEL_WPTR = 2'h2;
	// word address to byte address shift
	localparam int BYTE_SHIFT = 2;
	typedef enum logic [2:0] {
		DM_IDLE = 3'b001,
		DM_WR = 3'b010,
		DM_RD = 3'b100
	} hpdr_dma_e;
endpackage : hpdr_pkg

// file: design/hpdr_top.sv
// host port data window and address pointers with queues and dma
// assumes host strobes only while host_rdy is high, memory acks once
// Operation
// - host write fills data word, dma then writes it to memory
// - host read: dma loads data word from memory, then host gets it
// - one cycle is one 32-bit or two 16-bit transfers
// - host reads and writes data word; cpu has no path to it
// - data accesses pop a read queue or push a write queue
// - two 32-bit pointers: one for reads, one for writes
// - single mode shares one pointer, dual mode keeps two; cpu OFS_WR_PTR reads and dma writes use wptr_q in either mode
// - host reads and writes pointers; cpu reads only, writes ignored
// - hardware reset clears the data word to zero
// - both pointers read zero after reset to host and cpu
// - order bit 0: first halfword high; 1: first halfword low
//
// Added by the designer: the AHB-Lite register port and the register offsets.
module hpdr_top #(
	parameter int FIFO_DEPTH = hpdr_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic srst,
	// ahb-lite slave, cpu side
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// configuration from the host control register
	input wire logic mode_16,
	input wire logic dual_ptr_mode,
	input wire logic halfword_order_bit,
	// host cycle port
	input wire logic host_stb,
	input wire logic host_rnw,
	input wire logic [1:0] host_sel,
	input wire logic [31:0] host_wdata,
	output logic host_rdy,
	output logic host_ack,
	output logic [31:0] host_rdata,
	// internal memory port
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);
	// ==================================================
	// state
	// ==================================================
	logic [31:0] data_q;
	logic [31:0] rptr_q;
	logic [31:0] wptr_q;
	logic [15:0] hold_q;
	logic half_q;
	logic rd_pend_q;
	logic rd_busy_q;
	logic pop_wait_q;
	logic rd_half_q;
	hpdr_pkg::hpdr_dma_e dma_q;

	hpdr_fifo_if #(.W(hpdr_pkg::DATA_W)) wf ();
	hpdr_fifo_if #(.W(hpdr_pkg::DATA_W)) rf ();

	hpdr_fifo #(.W(hpdr_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
		.mclk(mclk),
		.srst(srst),
		.q(wf)
	);
	hpdr_fifo #(.W(hpdr_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_rfifo (
		.mclk(mclk),
		.srst(srst),
		.q(rf)
	);

	// ==================================================
	// host transfer decode
	// ==================================================
	logic take;
	logic last_half;
	logic first_half;
	logic [31:0] word_in;
	logic wr_end;
	logic data_rd_start;

	assign take = host_stb && host_rdy;
	assign first_half = !mode_16 || !half_q;
	assign last_half = !mode_16 || half_q;

	always_comb
	begin
		word_in = host_wdata;
		if (mode_16)
		begin
			if (halfword_order_bit)
				word_in = {host_wdata[15:0], hold_q};
			else
				word_in = {hold_q, host_wdata[15:0]};
		end
	end

	assign wr_end = take && !host_rnw && last_half;
	assign data_rd_start = take && host_rnw && first_half
		&& host_sel == hpdr_pkg::SEL_DATA;

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			half_q <= 1'b0;
			hold_q <= '0;
		end
		else if (take && mode_16)
		begin
			half_q <= !half_q;
			hold_q <= host_wdata[15:0];
		end
	end

	// ==================================================
	// address pointers
	// ==================================================
	// pointers reset to zero
	// only the host port writes them
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			rptr_q <= hpdr_pkg::PTR_RST;
			wptr_q <= hpdr_pkg::PTR_RST;
		end
		else if (wr_end)
		begin
			if (host_sel == hpdr_pkg::SEL_RPTR)
			begin
				rptr_q <= word_in;
				if (!dual_ptr_mode)
					wptr_q <= word_in;
			end
			else if (host_sel == hpdr_pkg::SEL_WPTR)
			begin
				wptr_q <= word_in;
				if (!dual_ptr_mode)
					rptr_q <= word_in;
			end
		end
	end

	// ==================================================
	// data window and write queue
	// ==================================================
	// full word into the write queue
	assign wf.push = wr_end && host_sel == hpdr_pkg::SEL_DATA;
	assign wf.wdata = word_in;

	always_ff @(posedge mclk)
	begin
		if (srst)
			data_q <= hpdr_pkg::DATA_RST;
		else if (wf.push)
			data_q <= word_in;
		else if (pop_wait_q)
			data_q <= rf.rdata;
	end

	// ==================================================
	// dma engine
	// ==================================================
	logic start_wr;
	logic start_rd;

	// writes drain first so a read sees earlier writes
	assign start_wr = dma_q == hpdr_pkg::DM_IDLE && !wf.empty;
	assign start_rd = dma_q == hpdr_pkg::DM_IDLE && wf.empty && rd_pend_q
		&& !rd_busy_q && rf.empty;
	assign wf.pop = start_wr;
	assign rf.pop = rd_pend_q && !rf.empty && !pop_wait_q;
	assign rf.push = dma_q == hpdr_pkg::DM_RD && mem_ack;
	assign rf.wdata = mem_rdata;

	always_ff @(posedge mclk)
	begin
		if (srst)
			dma_q <= hpdr_pkg::DM_IDLE;
		else
		begin
			unique case (dma_q)
				hpdr_pkg::DM_IDLE:
				begin
					if (start_wr)
						dma_q <= hpdr_pkg::DM_WR;
					else if (start_rd)
						dma_q <= hpdr_pkg::DM_RD;
				end
				hpdr_pkg::DM_WR:
				begin
					if (mem_ack)
						dma_q <= hpdr_pkg::DM_IDLE;
				end
				hpdr_pkg::DM_RD:
				begin
					if (mem_ack)
						dma_q <= hpdr_pkg::DM_IDLE;
				end
			endcase
		end
	end

	// write data appears one cycle after the pop
	logic wr_load_q;
	always_ff @(posedge mclk)
	begin
		if (srst)
			wr_load_q <= 1'b0;
		else
			wr_load_q <= start_wr;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= '0;
		end
		else if (mem_req && mem_ack)
			mem_req <= 1'b0;
		else if (wr_load_q)
		begin
			mem_req <= 1'b1;
			mem_we <= 1'b1;
			mem_wdata <= wf.rdata;
			mem_addr <= wptr_q << hpdr_pkg::BYTE_SHIFT;
		end
		else if (start_rd)
		begin
			mem_req <= 1'b1;
			mem_we <= 1'b0;
			mem_addr <= rptr_q << hpdr_pkg::BYTE_SHIFT;
		end
	end

	// ==================================================
	// host read sequencing
	// ==================================================
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			rd_pend_q <= 1'b0;
			rd_busy_q <= 1'b0;
			pop_wait_q <= 1'b0;
		end
		else
		begin
			pop_wait_q <= rf.pop;
			if (data_rd_start)
				rd_pend_q <= 1'b1;
			else if (pop_wait_q)
				rd_pend_q <= 1'b0;
			if (start_rd)
				rd_busy_q <= 1'b1;
			else if (pop_wait_q)
				rd_busy_q <= 1'b0;
		end
	end

	// ==================================================
	// host answers
	// ==================================================
	logic [31:0] rd_src;
	always_comb
	begin
		unique case (host_sel)
			hpdr_pkg::SEL_RPTR: rd_src = rptr_q;
			hpdr_pkg::SEL_WPTR: rd_src = dual_ptr_mode ? wptr_q : rptr_q;
			default: rd_src = data_q;
		endcase
	end

	// pick the halfword for this phase
	function automatic logic [31:0] pick_half(
		input logic [31:0] w,
		input logic second
	);
		logic hi;
		hi = second ? halfword_order_bit : !halfword_order_bit;
		pick_half = {16'h0000, hi ? w[31:16] : w[15:0]};
	endfunction : pick_half

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			host_ack <= 1'b0;
			host_rdata <= '0;
			host_rdy <= 1'b1;
			rd_half_q <= 1'b0;
		end
		else
		begin
			host_ack <= 1'b0;
			if (data_rd_start)
			begin
				host_rdy <= 1'b0;
				rd_half_q <= half_q;
			end
			else if (pop_wait_q)
			begin
				// word passed to host after load
				host_ack <= 1'b1;
				host_rdy <= 1'b1;
				host_rdata <= mode_16 ? pick_half(rf.rdata, rd_half_q)
					: rf.rdata;
			end
			else if (take)
			begin
				host_ack <= 1'b1;
				if (host_rnw)
					host_rdata <= mode_16 ? pick_half(rd_src, half_q)
						: rd_src;
				// stall when a push finds the write queue full
				host_rdy <= !(wf.push && wf.full);
			end
			// a pending data fetch keeps the host stalled until the word lands
			else
				host_rdy <= !wf.full && !rd_pend_q;
		end
	end

	// ==================================================
	// ahb-lite slave, cpu side
	// ==================================================
	logic ahb_take;
	logic [31:0] cpu_rd;
	logic [31:0] status;

	assign ahb_take = hsel && htrans[1] && hready;
	always_comb
	begin
		status = '0;
		status[hpdr_pkg::ST_DUAL_POS] = dual_ptr_mode;
		status[hpdr_pkg::ST_WF_EMPTY_POS] = wf.empty;
		status[hpdr_pkg::ST_RF_EMPTY_POS] = rf.empty;
		status[hpdr_pkg::ST_BUSY_POS] = dma_q != hpdr_pkg::DM_IDLE;
	end

	// data word has no cpu address
	always_comb
	begin
		unique case (haddr[7:0])
			hpdr_pkg::OFS_RD_PTR: cpu_rd = rptr_q;
			hpdr_pkg::OFS_WR_PTR: cpu_rd = wptr_q;
			hpdr_pkg::OFS_STATUS: cpu_rd = status;
			default: cpu_rd = '0;
		endcase
	end

	// cpu writes are accepted and dropped
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (ahb_take && !hwrite)
				hrdata <= (haddr[31:8] == '0) ? cpu_rd : '0;
		end
	end

	logic unused;
	assign unused = ^{hsize, hwdata, host_wdata[31:16] & 16'h0000};
endmodule : hpdr_top

// file: sim/hpdr_mem_model.sv
// word memory on the dma port, answers after lat idle cycles
// assumes one request at a time, held until the ack
module hpdr_mem_model (
	input wire logic mclk,
	input wire logic [3:0] lat,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [0:15];
	logic [3:0] wait_q;
	logic [31:0] last_q;
	initial
	begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
		wait_q = 4'h0;
		last_q = 32'h0;
	end
	// ========================================
	// answer; read data is garbage outside the ack cycle
	always @(posedge mclk)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~last_q;
		if (mem_req && !mem_ack)
		begin
			if (wait_q >= lat)
			begin
				wait_q <= 4'h0;
				mem_ack <= 1'b1;
				if (mem_we)
					mem[mem_addr[5:2]] <= mem_wdata;
				else
				begin
					mem_rdata <= mem[mem_addr[5:2]];
					last_q <= mem[mem_addr[5:2]];
				end
			end
			else
				wait_q <= wait_q + 4'h1;
		end
	end
endmodule : hpdr_mem_model

// file: sim/hpdr_top_sva.sv
// checker for the host port register block, bound to hpdr_top
// assumes one clock and a synchronous active-high reset
module hpdr_chk (
	input wire logic mclk,
	input wire logic srst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic mode_16,
	input wire logic host_stb,
	input wire logic host_rnw,
	input wire logic [1:0] host_sel,
	input wire logic host_rdy,
	input wire logic host_ack,
	input wire logic [31:0] host_rdata,
	input wire logic mem_req,
	input wire logic mem_ack,
	input wire logic [31:0] mem_addr
);
	// ========================================
	// properties
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	chk_bus_okay: assert property (
		hresp == 1'b0 && hreadyout == 1'b1)
		else $error("bus slave not ready or not okay");
	chk_ack_single: assert property (
		host_ack |=> !host_ack)
		else $error("transfer done held too long");
	chk_wr_ack: assert property (
		host_stb && host_rdy && !host_rnw && !mode_16 |=> host_ack)
		else $error("write transfer not answered");
	chk_rd_fetch: assert property (
		host_stb && host_rdy && host_rnw && host_sel == 2'h0 && !mode_16
		|=> !host_rdy && !host_ack)
		else $error("data read answered before fetch");
	chk_req_hold: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("memory request dropped or moved");
	chk_req_drop: assert property (
		mem_req && mem_ack |=> !mem_req)
		else $error("memory request held after ack");
	chk_byte_addr: assert property (
		mem_req |-> mem_addr[1:0] == 2'h0)
		else $error("memory address not word aligned");
	chk_reset_zero: assert property (
		$past(srst) |-> host_rdata == 32'h0 && hrdata == 32'h0)
		else $error("data not zero after reset");
	chk_rdata_hold: assert property (
		!host_ack |-> $stable(host_rdata))
		else $error("read data changed without ack");
endmodule : hpdr_chk

// file: sim/tb_hpdr_top.sv
// self-checking bench for hpdr_top with a memory model on the dma port
// assumes the checker and the memory model are compiled first
module tb_hpdr_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic mode_16 = 1'b0, dual_ptr_mode = 1'b0, halfword_order_bit = 1'b0;
	logic host_stb = 1'b0, host_rnw = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, host_wdata = 32'h0;
	logic [1:0] htrans = 2'h0, host_sel = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] lat = 4'h0;
	logic hreadyout, hresp, host_rdy, host_ack, mem_req, mem_we, mem_ack;
	logic [31:0] hrdata, host_rdata, mem_addr, mem_wdata, mem_rdata;
	wire logic hready;
	int err_total = 0;
	int cmp_count = 0;
	assign hready = hreadyout;
	always #5 mclk = ~mclk;
	hpdr_top dut (.mclk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .mode_16,
		.dual_ptr_mode, .halfword_order_bit, .host_stb, .host_rnw,
		.host_sel, .host_wdata, .host_rdy, .host_ack, .host_rdata,
		.mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
	hpdr_mem_model u_mem (.mclk, .lat, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_ack, .mem_rdata);
	// ========================================
	// bus and compare tasks
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic ahb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk); while (!hready);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge mclk); while (!hready);
		r = hrdata;
	endtask : ahb
	task automatic hst(input logic [1:0] s, input logic rnw,
		input logic [31:0] d, output logic [31:0] r);
		do @(posedge mclk); while (!host_rdy);
		host_stb <= 1'b1;
		host_sel <= s;
		host_rnw <= rnw;
		host_wdata <= d;
		@(posedge mclk);
		host_stb <= 1'b0;
		do @(posedge mclk); while (!host_ack);
		r = host_rdata;
	endtask : hst
	// two halves of one cycle, order from the halfword order bit
	task automatic hx(input logic [1:0] s, input logic rnw,
		input logic [31:0] v, output logic [31:0] r);
		logic [31:0] a;
		logic [31:0] b;
		hst(s, rnw, halfword_order_bit ? v : v >> 16, a);
		hst(s, rnw, halfword_order_bit ? v >> 16 : v, b);
		r = halfword_order_bit ? {b[15:0], a[15:0]} : {a[15:0], b[15:0]};
	endtask : hx
	// ========================================
	// scenarios
	task automatic t_reset();
		logic [31:0] r;
		ahb(hpdr_pkg::OFS_RD_PTR, 1'b0, 32'h0, r);
		chk(r, hpdr_pkg::PTR_RST);
		ahb(hpdr_pkg::OFS_WR_PTR, 1'b0, 32'h0, r);
		chk(r, hpdr_pkg::PTR_RST);
		hst(hpdr_pkg::SEL_RPTR, 1'b1, 32'h0, r);
		chk(r, hpdr_pkg::PTR_RST);
		ahb(8'h0c, 1'b0, 32'h0, r);
		chk(r, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_ptr();
		logic [31:0] r;
		@(posedge mclk);
		dual_ptr_mode <= 1'b1;
		hst(hpdr_pkg::SEL_RPTR, 1'b0, 32'h3, r);
		hst(hpdr_pkg::SEL_WPTR, 1'b0, 32'h5, r);
		ahb(hpdr_pkg::OFS_RD_PTR, 1'b0, 32'h0, r);
		chk(r, 32'h3);
		ahb(hpdr_pkg::OFS_WR_PTR, 1'b0, 32'h0, r);
		chk(r, 32'h5);
		ahb(hpdr_pkg::OFS_RD_PTR, 1'b1, 32'hffff_ffff, r);
		ahb(hpdr_pkg::OFS_RD_PTR, 1'b0, 32'h0, r);
		chk(r, 32'h3);
		hst(hpdr_pkg::SEL_WPTR, 1'b1, 32'h0, r);
		chk(r, 32'h5);
		@(posedge mclk);
		dual_ptr_mode <= 1'b0;
		hst(hpdr_pkg::SEL_WPTR, 1'b0, 32'h7, r);
		ahb(hpdr_pkg::OFS_RD_PTR, 1'b0, 32'h0, r);
		chk(r, 32'h7);
		$display("test pointers done");
	endtask : t_ptr
	task automatic t_data();
		logic [31:0] r;
		@(posedge mclk);
		dual_ptr_mode <= 1'b1;
		hst(hpdr_pkg::SEL_RPTR, 1'b0, 32'h2, r);
		hst(hpdr_pkg::SEL_WPTR, 1'b0, 32'h2, r);
		hst(hpdr_pkg::SEL_DATA, 1'b0, 32'hcafe_0001, r);
		@(posedge mclk);
		lat <= 4'h6;
		hst(hpdr_pkg::SEL_DATA, 1'b1, 32'h0, r);
		chk(r, 32'hcafe_0001);
		chk(u_mem.mem[2], 32'hcafe_0001);
		u_mem.mem[9] = 32'h1234_5678;
		hst(hpdr_pkg::SEL_RPTR, 1'b0, 32'h9, r);
		hst(hpdr_pkg::SEL_DATA, 1'b1, 32'h0, r);
		chk(r, 32'h1234_5678);
		ahb(hpdr_pkg::OFS_STATUS, 1'b0, 32'h0, r);
		chk(r, (32'h1 << hpdr_pkg::ST_DUAL_POS)
			| (32'h1 << hpdr_pkg::ST_WF_EMPTY_POS)
			| (32'h1 << hpdr_pkg::ST_RF_EMPTY_POS));
		$display("test data done");
	endtask : t_data
	task automatic t_half();
		logic [31:0] r;
		@(posedge mclk);
		mode_16 <= 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			@(posedge mclk);
			halfword_order_bit <= i[0];
			@(posedge mclk);
			hx(hpdr_pkg::SEL_RPTR, 1'b0, 32'h00ab_0cde, r);
			ahb(hpdr_pkg::OFS_RD_PTR, 1'b0, 32'h0, r);
			chk(r, 32'h00ab_0cde);
			hx(hpdr_pkg::SEL_RPTR, 1'b1, 32'h0, r);
			chk(r, 32'h00ab_0cde);
		end
		$display("test halfwords done");
	endtask : t_half
	initial
	begin
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		t_reset();
		t_ptr();
		t_data();
		t_half();
		end_of_test();
	end
	// the tests need well under 2000 cycles; allow ten times that
	initial
	begin
		#200us;
		err_total++;
		$display("BAD t=%0t watchdog expired", $time);
		end_of_test();
	end
endmodule : tb_hpdr_top
bind hpdr_top hpdr_chk u_chk (.mclk, .srst, .hreadyout, .hresp, .hrdata,
	.mode_16, .host_stb, .host_rnw, .host_sel, .host_rdy, .host_ack,
	.host_rdata, .mem_req, .mem_ack, .mem_addr);
